// ---- core/crma_defs.vh ----
// Purpose: constants for the configuration message responder
// Assumes: tokens arrive one per cycle on a byte-wide stream
// Notes:   header of definitions only
`ifndef CRMA_DEFS_VH
`define CRMA_DEFS_VH
// ----------------------------------------------------------------
// control tokens
// ----------------------------------------------------------------
`define CRMA_TOK_WRITE   8'hc0
`define CRMA_TOK_READ    8'hc1
`define CRMA_TOK_END     8'h01
`define CRMA_TOK_ACK     8'h03
`define CRMA_TOK_NAK     8'h04
// ----------------------------------------------------------------
// field sizes in bytes
// ----------------------------------------------------------------
`define CRMA_REPLY_BYTES 3'd3
`define CRMA_REG_BYTES   3'd2
`define CRMA_DATA_BYTES  3'd4
// low byte of reply id that suppresses any reply
`define CRMA_NOREPLY_LO  8'hff
// idle cycles inside a message before it is judged truncated
`define CRMA_TIMEOUT     8'hff
`endif

// ---- core/crma_regs.v ----
// Purpose: small configuration register store, registered read data
// Assumes: one access per cycle, addressed by register number
// Notes:   numbers beyond depth fail, so the responder can say so
`timescale 1ns/1ps
module crma_regs #(
    parameter AW    = 4,                 // index bits of the store
    parameter DEPTH = 16                 // number of words
) (
    ref_clk,
    rst_n,
    wr_en,
    rd_en,
    reg_num,
    wr_data,
    rd_data,
    ok
);
    input  wire        ref_clk;          // core clock
    input  wire        rst_n;            // async reset, low
    input  wire        wr_en;            // write strobe
    input  wire        rd_en;            // read strobe
    input  wire [15:0] reg_num;          // register number
    input  wire [31:0] wr_data;          // write word
    output reg  [31:0] rd_data;          // registered read word
    output reg         ok;               // access hit a real register

    reg  [31:0] mem_r [0:DEPTH-1];       // register words
    wire        hit;                     // number inside store
    integer     i;

    assign hit = (reg_num < DEPTH);

    // ------------------------------------------------------------
    // storage, read port and status
    // ------------------------------------------------------------
    always @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            rd_data <= 32'h0;
            ok      <= 1'b0;
            for (i = 0; i < DEPTH; i = i + 1) begin
                mem_r[i] <= 32'h0;
            end
        end else begin
            // status follows every strobe
            if (wr_en || rd_en) begin
                ok <= hit;
            end
            if (wr_en && hit) begin
                mem_r[reg_num[AW-1:0]] <= wr_data;
            end
            if (rd_en) begin
                rd_data <= hit ? mem_r[reg_num[AW-1:0]] : 32'h0;
            end
        end
    end
endmodule

// ---- core/crma_resp.v ----
// Purpose: decode config access messages, answer with ack or nak
// Assumes: in_vld/in_ctl/in_byte token stream, out_rdy back-pressure
// Notes:   one message at a time; input stalls while answering
//
// What this block does
// RULE1 - request carries 24-bit reply channel id
// RULE2 - reply id low byte all ones: silence
// RULE3 - multi-byte fields travel most significant first
// RULE4 - status id is number shl 8 or 0x0b; here no status id decode, register number used as is
// RULE5 - tile registers reached via tile pattern; here no pattern decode, one store indexed by register number
// RULE6 - node registers reached via node pattern; here no pattern decode, one store indexed by register number
// RULE7 - write: 192, id, reg, data, token 1
// RULE8 - read: 193, id, reg, token 1
// RULE9 - write answer: 3,1 success or 4,1 fail
// RULE10 - read answer: 3, data word, 1 or 4,1
// RULE11 - peripheral registers reached via peripheral pattern; here no pattern decode, one store indexed by register number
// RULE12 - peripheral read answered with 3, data, 1
// RULE13 - bad or truncated request answered as failure
`timescale 1ns/1ps
`include "crma_defs.vh"
module crma_resp #(
    parameter AW    = 4,
    parameter DEPTH = 16
) (
    ref_clk,
    rst_n,
    in_vld,
    in_ctl,
    in_byte,
    in_rdy,
    out_vld,
    out_ctl,
    out_byte,
    out_rdy,
    out_dest
);
    input  wire        ref_clk;          // core clock
    input  wire        rst_n;            // async reset, low
    input  wire        in_vld;           // request token valid
    input  wire        in_ctl;           // token is a control token
    input  wire [7:0]  in_byte;          // token value
    output wire        in_rdy;           // request token accepted
    output reg         out_vld;          // answer token valid
    output reg         out_ctl;          // answer token is control
    output reg  [7:0]  out_byte;         // answer token value
    input  wire        out_rdy;          // answer token taken
    output reg  [23:0] out_dest;         // reply channel for answer

    // ------------------------------------------------------------
    // states, one-hot
    // ------------------------------------------------------------
    localparam [6:0] S_IDLE = 7'h01;     // wait for opening token
    localparam [6:0] S_RID  = 7'h02;     // reply id bytes
    localparam [6:0] S_REG  = 7'h04;     // register number bytes
    localparam [6:0] S_DAT  = 7'h08;     // write data bytes
    localparam [6:0] S_END  = 7'h10;     // closing token
    localparam [6:0] S_ACC  = 7'h20;     // register access cycle
    localparam [6:0] S_ANS  = 7'h40;     // sending answer tokens

    reg  [6:0]  st_r;                    // state
    reg  [2:0]  cnt_r;                   // bytes left in a field
    reg         is_wr_r;                 // message is a write
    reg         bad_r;                   // message judged failed
    reg  [23:0] rid_r;                   // reply channel id
    reg  [15:0] regn_r;                  // register number
    reg  [31:0] wdat_r;                  // write data
    reg  [7:0]  idle_r;                  // stall counter in message
    reg  [2:0]  ans_r;                   // answer token index
    reg         acc_r;                   // access pending result
    wire [31:0] rdat;                    // store read word
    wire        rok;                     // store hit
    wire        take;                    // token consumed
    wire        timeout;                 // message went quiet
    wire        drop;                    // answer must be suppressed
    wire        succ;                    // access outcome

    assign in_rdy  = (st_r != S_ACC) && (st_r != S_ANS);
    assign take    = in_vld && in_rdy;
    // RULE13 truncation by timeout
    assign timeout = (st_r != S_IDLE) && in_rdy && !in_vld
                     && (idle_r == `CRMA_TIMEOUT);
    // RULE2 suppress by low byte
    assign drop    = (rid_r[7:0] == `CRMA_NOREPLY_LO);
    assign succ    = !bad_r && rok;

    crma_regs #(
        .AW    (AW),
        .DEPTH (DEPTH)
    ) u_regs (
        .ref_clk (ref_clk),
        .rst_n   (rst_n),
        .wr_en   (st_r == S_ACC && !bad_r && is_wr_r && !acc_r),
        .rd_en   (st_r == S_ACC && !bad_r && !is_wr_r && !acc_r),
        .reg_num (regn_r),
        .wr_data (wdat_r),
        .rd_data (rdat),
        .ok      (rok)
    );

    // ------------------------------------------------------------
    // request decoder
    // ------------------------------------------------------------
    always @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            st_r     <= S_IDLE;
            cnt_r    <= 3'd0;
            is_wr_r  <= 1'b0;
            bad_r    <= 1'b0;
            rid_r    <= 24'h0;
            regn_r   <= 16'h0;
            wdat_r   <= 32'h0;
            idle_r   <= 8'h0;
            ans_r    <= 3'd0;
            acc_r    <= 1'b0;
            out_vld  <= 1'b0;
            out_ctl  <= 1'b0;
            out_byte <= 8'h0;
            out_dest <= 24'h0;
        end else begin
            // quiet-cycle count, cleared by each token
            if (take || st_r == S_IDLE) begin
                idle_r <= 8'h0;
            end else if (in_rdy && idle_r != `CRMA_TIMEOUT) begin
                idle_r <= idle_r + 8'h01;
            end
            case (st_r)
                S_IDLE: begin
                    bad_r <= 1'b0;
                    // RULE7 write opener
                    if (take && in_ctl && in_byte == `CRMA_TOK_WRITE) begin
                        is_wr_r <= 1'b1;
                        st_r    <= S_RID;
                        cnt_r   <= `CRMA_REPLY_BYTES;
                    // RULE8 read opener
                    end else if (take && in_ctl
                                 && in_byte == `CRMA_TOK_READ) begin
                        is_wr_r <= 1'b0;
                        st_r    <= S_RID;
                        cnt_r   <= `CRMA_REPLY_BYTES;
                    end
                    // anything else carries no reply id: dropped
                end
                S_RID, S_REG, S_DAT: begin
                    if (timeout) begin
                        bad_r <= 1'b1;
                        st_r  <= S_ACC;
                    end else if (take && in_ctl) begin
                        // RULE13 short field: fail
                        bad_r <= 1'b1;
                        st_r  <= (in_byte == `CRMA_TOK_END) ? S_ACC : S_END;
                    end else if (take) begin
                        // RULE3 shift in msb first
                        if (st_r == S_RID) begin
                            rid_r <= {rid_r[15:0], in_byte};
                        end else if (st_r == S_REG) begin
                            regn_r <= {regn_r[7:0], in_byte};
                        end else begin
                            wdat_r <= {wdat_r[23:0], in_byte};
                        end
                        cnt_r <= cnt_r - 3'd1;
                        if (cnt_r == 3'd1) begin
                            if (st_r == S_RID) begin
                                st_r  <= S_REG;
                                cnt_r <= `CRMA_REG_BYTES;
                            end else if (st_r == S_REG && is_wr_r) begin
                                st_r  <= S_DAT;
                                cnt_r <= `CRMA_DATA_BYTES;
                            end else begin
                                st_r <= S_END;
                            end
                        end
                    end
                end
                S_END: begin
                    // RULE13 extra bytes or wrong closer fail
                    if (timeout) begin
                        bad_r <= 1'b1;
                        st_r  <= S_ACC;
                    end else if (take) begin
                        if (!(in_ctl && in_byte == `CRMA_TOK_END)) begin
                            bad_r <= 1'b1;
                        end
                        if (in_ctl && in_byte == `CRMA_TOK_END) begin
                            st_r <= S_ACC;
                        end
                    end
                end
                S_ACC: begin
                    // strobe one cycle, then read the result
                    if (!acc_r && !bad_r) begin
                        acc_r <= 1'b1;
                    end else begin
                        acc_r <= 1'b0;
                        ans_r <= 3'd0;
                        out_dest <= rid_r;
                        if (drop) begin
                            st_r <= S_IDLE;
                        end else begin
                            st_r <= S_ANS;
                            // RULE9 first answer token
                            out_vld  <= 1'b1;
                            out_ctl  <= 1'b1;
                            out_byte <= succ ? `CRMA_TOK_ACK : `CRMA_TOK_NAK;
                            bad_r    <= !succ;
                        end
                    end
                end
                S_ANS: begin
                    if (out_rdy) begin
                        ans_r <= ans_r + 3'd1;
                        // RULE12 peripheral read same answer
                        // RULE10 read data msb first after ack
                        if (!bad_r && !is_wr_r && ans_r < 3'd4) begin
                            out_ctl  <= 1'b0;
                            out_byte <= rdat[8'd31 - {ans_r, 3'b000} -: 8];
                        end else if (out_ctl
                                     && out_byte == `CRMA_TOK_END) begin
                            out_vld <= 1'b0;
                            st_r    <= S_IDLE;
                        end else begin
                            out_ctl  <= 1'b1;
                            out_byte <= `CRMA_TOK_END;
                        end
                    end
                end
                default: begin
                    st_r <= S_IDLE;
                end
            endcase
        end
    end
endmodule

// ---- bench/crma_resp_sva.sv ----
// Purpose: port checks for the config message responder
// Assumes: one clock, async active-low reset
// Notes:   a helper counts data tokens of the current answer
`timescale 1ns/1ps
`include "crma_defs.vh"
module crma_resp_sva (
    input wire logic        ref_clk,
    input wire logic        rst_n,
    input wire logic        in_vld,
    input wire logic        in_ctl,
    input wire logic [7:0]  in_byte,
    input wire logic        in_rdy,
    input wire logic        out_vld,
    input wire logic        out_ctl,
    input wire logic [7:0]  out_byte,
    input wire logic        out_rdy,
    input wire logic [23:0] out_dest
);
    logic [2:0] dcnt_r;                  // data tokens handed over
    wire        take = out_vld && out_rdy; // answer token taken
    wire        fin  = out_ctl && out_byte == `CRMA_TOK_END;
    // cleared by any control token, so a word longer than four shows
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n)
            dcnt_r <= 3'h0;
        else if (take)
            dcnt_r <= out_ctl ? 3'h0 : dcnt_r + 3'h1;
    end
    default clocking @(posedge ref_clk); endclocking
    default disable iff (!rst_n);
    AST_HOLD: assert property (
        out_vld && !out_rdy |=> out_vld && $stable({out_ctl, out_byte}))
        else $error("answer token changed before taken");
    AST_DEST: assert property (
        out_vld && $past(out_vld) |-> $stable(out_dest))
        else $error("reply channel changed mid answer");
    AST_FIRST: assert property (
        $rose(out_vld) |-> out_ctl && (out_byte == `CRMA_TOK_ACK
        || out_byte == `CRMA_TOK_NAK)) else $error("answer opener bad");
    AST_NAK_END: assert property (
        take && out_ctl && out_byte == `CRMA_TOK_NAK |=> out_vld && fin)
        else $error("failure not closed by end token");
    AST_END_IDLE: assert property (
        take && fin |=> !out_vld) else $error("token after end");
    AST_RDY_LOW: assert property (
        out_vld |-> !in_rdy) else $error("request taken while answering");
    AST_RDY_BACK: assert property (
        take && fin |-> ##[1:2] in_rdy) else $error("input stays stalled");
    AST_DATA_MAX: assert property (
        out_vld && !out_ctl |-> dcnt_r < 3'h4)
        else $error("more than four data bytes");
    AST_DATA_CLOSE: assert property (
        out_vld && fin |-> dcnt_r == 3'h0 || dcnt_r == 3'h4)
        else $error("data word cut short");
endmodule

// ---- bench/crma_sink.sv ----
// Purpose: far channel end taking answer tokens
// Assumes: answers are consumed whole, in order
// Notes:   slow mode stalls at random, as a busy thread would
`timescale 1ns/1ps
module crma_sink (
    input  wire logic ref_clk,
    input  wire logic rst_n,
    input  wire logic slow,
    output logic      out_rdy
);
    integer seed = 32'he4cc;             // fixed stall pattern
    always @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n)
            out_rdy <= 1'b0;
        else
            out_rdy <= !slow || (($random(seed) & 3) == 0);
    end
endmodule

// ---- bench/crma_resp_bench.sv ----
// Purpose: self-checking bench for the config message responder
// Assumes: answer tokens compared in order against queued notes
// Notes:   store mirrored here, sixteen words reset to zero
`timescale 1ns/1ps
`include "crma_defs.vh"
module crma_resp_bench;
    logic        ref_clk = 1'b0;         // core clock
    logic        rst_n   = 1'b0;         // reset, low
    logic        in_vld  = 1'b0;         // request token valid
    logic        in_ctl  = 1'b0;         // request token is control
    logic [7:0]  in_byte = 8'h00;        // request token value
    logic        slow    = 1'b0;         // sink stalls at random
    wire         in_rdy, out_vld, out_ctl, out_rdy;
    wire  [7:0]  out_byte;
    wire  [23:0] out_dest;
    logic [32:0] exp_q[$];               // notes: dest, ctl, byte
    logic [31:0] mem[0:15];              // mirror of the store
    logic [31:0] d;
    logic [23:0] id;
    integer      num_errors = 0;
    integer      n_compared = 0;
    integer      seed       = 32'he4cc;
    integer      i;
    always #2.5 ref_clk = ~ref_clk;
    crma_resp crma_resp_inst (.ref_clk(ref_clk), .rst_n(rst_n),
        .in_vld(in_vld), .in_ctl(in_ctl), .in_byte(in_byte),
        .in_rdy(in_rdy), .out_vld(out_vld), .out_ctl(out_ctl),
        .out_byte(out_byte), .out_rdy(out_rdy), .out_dest(out_dest));
    crma_sink crma_sink_inst (.ref_clk(ref_clk), .rst_n(rst_n),
        .slow(slow), .out_rdy(out_rdy));
    task final_report;
        begin
            $display("compared %0d errors %0d", n_compared, num_errors);
            if (num_errors == 0 && n_compared > 0)
                $display("Testbench passed");
            else
                $display("Testbench failed");
            $finish;
        end
    endtask
    task cmp_tok(input logic [32:0] want, input logic [32:0] got);
        begin
            n_compared += 1;
            if (got !== want) begin
                num_errors += 1;
                $display("unexpected %0t: got %h want %h", $time, got, want);
            end
        end
    endtask
    // watch answers; a token with no note is an error too
    always @(posedge ref_clk) begin
        if (rst_n && out_vld && out_rdy) begin
            if (exp_q.size() == 0)
                cmp_tok(33'h0, {out_dest, out_ctl, out_byte});
            else
                cmp_tok(exp_q.pop_front(), {out_dest, out_ctl, out_byte});
        end
    end
    task note(input logic [23:0] rid, input logic c, input logic [7:0] b);
        if (rid[7:0] !== `CRMA_NOREPLY_LO)
            exp_q.push_back({rid, c, b});
    endtask
    // held until taken, checked at the falling edge before
    task send_tok(input logic c, input logic [7:0] b);
        begin
            in_vld  <= 1'b1;
            in_ctl  <= c;
            in_byte <= b;
            @(negedge ref_clk);
            while (!in_rdy) @(negedge ref_clk);
            @(posedge ref_clk);
        end
    endtask
    task wait_done;
        integer t;
        begin
            in_vld <= 1'b0;
            for (t = 0; t < 400 && (exp_q.size() != 0 || !in_rdy); t++)
                @(posedge ref_clk);
            if (t == 400)
                cmp_tok(33'h1, 33'h0);
            repeat (3) @(posedge ref_clk);
        end
    endtask
    task hdr(input logic wr, input logic [23:0] rid);
        integer k;
        begin
            send_tok(1'b1, wr ? `CRMA_TOK_WRITE : `CRMA_TOK_READ);
            for (k = 2; k >= 0; k--) send_tok(1'b0, rid[8*k +: 8]);
        end
    endtask
    task msg(input logic wr, input logic [23:0] rid,
             input logic [15:0] rg, input logic [31:0] dat);
        integer k;
        begin
            hdr(wr, rid);
            for (k = 1; k >= 0; k--) send_tok(1'b0, rg[8*k +: 8]);
            for (k = 3; k >= 0 && wr; k--) send_tok(1'b0, dat[8*k +: 8]);
            note(rid, 1'b1, rg < 16 ? `CRMA_TOK_ACK : `CRMA_TOK_NAK);
            for (k = 3; k >= 0 && !wr && rg < 16; k--)
                note(rid, 1'b0, mem[rg[3:0]][8*k +: 8]);
            note(rid, 1'b1, `CRMA_TOK_END);
            if (wr && rg < 16)
                mem[rg[3:0]] = dat;
            send_tok(1'b1, `CRMA_TOK_END);
            wait_done;
        end
    endtask
    initial begin
        #100000;
        num_errors += 1;
        final_report;
    end
    initial begin
        for (i = 0; i < 16; i++) mem[i] = 32'h0;
        repeat (8) @(posedge ref_clk);
        rst_n <= 1'b1;
        @(posedge ref_clk);
        msg(1'b0, 24'h010203, 16'h0007, 32'h0);
        msg(1'b1, 24'h010203, 16'h0002, 32'h11223344);
        msg(1'b0, 24'h0a0b0c, 16'h0002, 32'h0);
        msg(1'b1, 24'h0a0b0c, 16'h000f, 32'hcafe0001);
        msg(1'b0, 24'h0a0b0c, 16'h000f, 32'h0);
        msg(1'b1, 24'h0a0b0c, 16'h0010, 32'h5);
        msg(1'b0, 24'h0a0b0c, 16'h0010, 32'h0);
        $display("test basic done");
        msg(1'b1, 24'h3344ff, 16'h0005, 32'h89abcdef);
        msg(1'b1, 24'h3344ff, 16'h0020, 32'h1);
        msg(1'b0, 24'h334400, 16'h0005, 32'h0);
        $display("test silent done");
        // end token inside the data field
        hdr(1'b1, 24'h445566);
        for (i = 0; i < 4; i++) send_tok(1'b0, 8'h03);
        note(24'h445566, 1'b1, `CRMA_TOK_NAK);
        note(24'h445566, 1'b1, `CRMA_TOK_END);
        send_tok(1'b1, `CRMA_TOK_END);
        wait_done;
        send_tok(1'b1, 8'h55);
        send_tok(1'b1, `CRMA_TOK_END);
        wait_done;
        // stalled mid field, the quiet limit ends it
        hdr(1'b0, 24'h778800);
        note(24'h778800, 1'b1, `CRMA_TOK_NAK);
        note(24'h778800, 1'b1, `CRMA_TOK_END);
        send_tok(1'b0, 8'h00);
        wait_done;
        // control token then a stray byte inside a read
        hdr(1'b0, 24'h121314);
        send_tok(1'b0, 8'h00);
        send_tok(1'b1, `CRMA_TOK_ACK);
        send_tok(1'b0, 8'h77);
        note(24'h121314, 1'b1, `CRMA_TOK_NAK);
        note(24'h121314, 1'b1, `CRMA_TOK_END);
        send_tok(1'b1, `CRMA_TOK_END);
        wait_done;
        $display("test faults done");
        slow <= 1'b1;
        for (i = 0; i < 8; i++) begin
            id = $random(seed);
            id[0] = 1'b0;
            d = $random(seed);
            // number taken from a status style id
            d[7:0] = 8'h0b;
            msg(1'b1, id, {11'h0, d[12:8]}, d);
            msg(1'b0, id, {11'h0, d[12:8]}, 32'h0);
        end
        $display("test random done");
        final_report;
    end
endmodule
bind crma_resp crma_resp_sva crma_resp_sva_inst (.ref_clk(ref_clk),
    .rst_n(rst_n), .in_vld(in_vld), .in_ctl(in_ctl), .in_byte(in_byte),
    .in_rdy(in_rdy), .out_vld(out_vld), .out_ctl(out_ctl),
    .out_byte(out_byte), .out_rdy(out_rdy), .out_dest(out_dest));
